// >>> self_wakeup_timer.v
// self wake-up timer: low-speed clocked 8-bit auto-reload counter with registers
`timescale 1ns/1ns
`include "wake_timer_regs.vh"

module self_wakeup_timer #(
	parameter PRE_W = 11
) (
	input wire mclk_i,
	input wire rst_i,
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	input wire lirc_i,
	input wire wake_irq_enable_i,
	input wire global_irq_enable_i,
	output reg wake_irq_req_o,
	output reg irq_o,
	output reg lirc_hold_o
);
	reg [7:0] wake_reload_byte;
	reg wake_overflow_flag;
	reg wake_run_bit;
	reg [2:0] wake_prescale_select;
	reg [7:0] event_status;
	reg [7:0] event_mask;
	reg [7:0] count;
	reg [PRE_W-1:0] prescale_cnt;
	reg run_q;
	reg [PRE_W-1:0] pre_limit;
	reg [7:0] next_rdata;
	wire lirc_tick;
	wire start;
	wire pre_done;
	wire step;
	wire overflow;
	wire wr_ctrl;
	wire rd_status;

	// sampling the oscillator level needs mclk at least twice its rate
	lirc_edge_sync u_sync (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.lirc_i(lirc_i),
		.tick_o(lirc_tick)
	);

	always @* begin
		case (wake_prescale_select)
			`PRESCALE_DIV1: pre_limit = 11'd0;
			`PRESCALE_DIV4: pre_limit = 11'd3;
			`PRESCALE_DIV16: pre_limit = 11'd15;
			`PRESCALE_DIV64: pre_limit = 11'd63;
			`PRESCALE_DIV256: pre_limit = 11'd255;
			`PRESCALE_DIV512: pre_limit = 11'd511;
			`PRESCALE_DIV1024: pre_limit = 11'd1023;
			default: pre_limit = 11'd2047;
		endcase
	end

	assign start = wake_run_bit & ~run_q;
	// no idle or power-down gating: the timer runs in every power mode
	assign pre_done = (prescale_cnt >= pre_limit);
	assign step = wake_run_bit & ~start & lirc_tick & pre_done;
	assign overflow = step & (count == `WAKE_COUNT_MAX);
	assign wr_ctrl = wr_i & (addr_i == `WAKE_TIMER_CONTROL_ADDR);
	assign rd_status = rd_i & (addr_i == `WAKE_EVENT_STATUS_ADDR);

	// prescaler and counter; both freeze while halted
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			prescale_cnt <= {PRE_W{1'b0}};
			count <= 8'h00;
			run_q <= 1'b0;
		end else begin
			run_q <= wake_run_bit;
			if (start) begin
				count <= wake_reload_byte;
			end else if (overflow) begin
				count <= wake_reload_byte;
			end else if (step) begin
				count <= count + 8'h01;
			end
			if (wake_run_bit & lirc_tick) begin
				if (pre_done) begin
					prescale_cnt <= {PRE_W{1'b0}};
				end else begin
					prescale_cnt <= prescale_cnt + {{(PRE_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

	// software registers; reload writes while running are not blocked
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			wake_reload_byte <= `WAKE_RELOAD_RESET;
			wake_overflow_flag <= 1'b0;
			wake_run_bit <= 1'b0;
			wake_prescale_select <= 3'h0;
			event_mask <= `WAKE_MASK_RESET;
		end else begin
			if (wr_i & (addr_i == `WAKE_RELOAD_BYTE_ADDR)) begin
				wake_reload_byte <= wdata_i;
			end
			if (wr_ctrl) begin
				wake_run_bit <= wdata_i[`WAKE_RUN_BIT];
				wake_prescale_select <= wdata_i[`WAKE_PRESCALE_HI:`WAKE_PRESCALE_LO];
			end
			// set wins over a clearing write in the same cycle
			if (overflow) begin
				wake_overflow_flag <= 1'b1;
			end else if (wr_ctrl) begin
				wake_overflow_flag <= wdata_i[`WAKE_OVERFLOW_FLAG_BIT];
			end
			if (wr_i & (addr_i == `WAKE_EVENT_MASK_ADDR)) begin
				event_mask <= wdata_i;
			end
		end
	end

	// sticky event status, cleared by reading it; new events win
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			event_status <= 8'h00;
		end else begin
			event_status <= (rd_status ? 8'h00 : event_status) |
				{6'h00, start, overflow};
		end
	end

	always @* begin
		next_rdata = 8'h00;
		case (addr_i)
			`WAKE_RELOAD_BYTE_ADDR: next_rdata = wake_reload_byte;
			`WAKE_TIMER_CONTROL_ADDR: next_rdata = {3'h0, wake_overflow_flag,
				wake_run_bit, wake_prescale_select};
			`WAKE_EVENT_STATUS_ADDR: next_rdata = event_status;
			`WAKE_EVENT_MASK_ADDR: next_rdata = event_mask;
			`WAKE_COUNT_VIEW_ADDR: next_rdata = count;
			default: next_rdata = 8'h00;
		endcase
	end

	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
			wake_irq_req_o <= 1'b0;
			irq_o <= 1'b0;
			lirc_hold_o <= 1'b0;
		end else begin
			rdata_o <= rd_i ? next_rdata : 8'h00;
			wake_irq_req_o <= wake_overflow_flag & wake_irq_enable_i &
				global_irq_enable_i;
			irq_o <= |(event_status & event_mask);
			// oscillator is not switched on by configuration, only kept on
			lirc_hold_o <= wake_run_bit;
		end
	end
endmodule

// >>> wake_timer_regs.vh
// register map, field positions and reset values of the wake-up timer
`ifndef WAKE_TIMER_REGS_VH
`define WAKE_TIMER_REGS_VH

`define WAKE_RELOAD_BYTE_ADDR 8'h86
`define WAKE_TIMER_CONTROL_ADDR 8'h8f
`define WAKE_EVENT_STATUS_ADDR 8'h90
`define WAKE_EVENT_MASK_ADDR 8'h91
`define WAKE_COUNT_VIEW_ADDR 8'h92

`define WAKE_OVERFLOW_FLAG_BIT 4
`define WAKE_RUN_BIT 3
`define WAKE_PRESCALE_HI 2
`define WAKE_PRESCALE_LO 0

`define WAKE_RELOAD_RESET 8'h00
`define WAKE_CONTROL_RESET 8'h00
`define WAKE_MASK_RESET 8'h00
`define WAKE_COUNT_MAX 8'hff

`define WAKE_EVT_OVERFLOW_BIT 0
`define WAKE_EVT_START_BIT 1

`define LIRC_FREQ_HZ 10000
`define MCLK_FREQ_HZ 100000000

`define PRESCALE_DIV1 3'h0
`define PRESCALE_DIV4 3'h1
`define PRESCALE_DIV16 3'h2
`define PRESCALE_DIV64 3'h3
`define PRESCALE_DIV256 3'h4
`define PRESCALE_DIV512 3'h5
`define PRESCALE_DIV1024 3'h6
`define PRESCALE_DIV2048 3'h7

`endif

// >>> lirc_edge_sync.v
// two-flop synchroniser and rising-edge tick for the low-speed oscillator
`timescale 1ns/1ns
module lirc_edge_sync (
	input wire mclk_i,
	input wire rst_i,
	input wire lirc_i,
	output reg tick_o
);
	reg meta;
	reg stable;
	reg stable_d;

	// only the second stage feeds the edge detector
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			meta <= 1'b0;
			stable <= 1'b0;
			stable_d <= 1'b0;
			tick_o <= 1'b0;
		end else begin
			meta <= lirc_i;
			stable <= meta;
			stable_d <= stable;
			tick_o <= stable & ~stable_d;
		end
	end
endmodule

// >>> self_wakeup_timer_chk.sv
// port checker for the self wake-up timer
`timescale 1ns/1ns
module self_wakeup_timer_chk #(parameter PRE_W = 11) (
	input wire mclk_i,
	input wire rst_i,
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	input wire [7:0] rdata_o,
	input wire lirc_i,
	input wire wake_irq_enable_i,
	input wire global_irq_enable_i,
	input wire wake_irq_req_o,
	input wire irq_o,
	input wire lirc_hold_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	sequence s_wr(a);
		wr_i && addr_i == a;
	endsequence
	sequence s_rd(a);
		rd_i && addr_i == a;
	endsequence
	property p_reload;
		logic [7:0] d;
		(s_wr(8'h86), d = wdata_i) ##2 s_rd(8'h86) |=> rdata_o == d;
	endproperty
	AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("rdata idle");
	AST_RELOAD_RW: assert property (p_reload)
		else $error("reload readback");
	AST_CTL_RSVD: assert property (s_rd(8'h8f) |=> rdata_o[7:5] == 3'h0)
		else $error("reserved bits");
	AST_CTL_RUN: assert property (s_rd(8'h8f) |=> rdata_o[3] == lirc_hold_o)
		else $error("hold vs run");
	AST_UNMAPPED: assert property (s_rd(8'h40) |=> rdata_o == 8'h00)
		else $error("unmapped read");
	AST_REQ_EN: assert property (wake_irq_req_o
		|-> $past(wake_irq_enable_i) && $past(global_irq_enable_i)) else $error("req enables");
	// only a software write may drop the flag, so the request stays with enables held
	AST_FLAG_STICKY: assert property (wake_irq_req_o && wake_irq_enable_i
		&& global_irq_enable_i && !$past(wr_i) |=> wake_irq_req_o) else $error("flag lost");
	AST_HOLD_STABLE: assert property (!$past(wr_i, 2) |-> $stable(lirc_hold_o))
		else $error("run changed");
	AST_IRQ_CLR: assert property (rd_i && addr_i == 8'h90 && !lirc_hold_o
		&& !$past(wr_i) |=> ##1 !irq_o) else $error("irq not cleared");
endmodule

// >>> testbench.sv
// self-checking bench for the self wake-up timer
`timescale 1ns/1ns
module testbench;
	reg mclk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, lirc_i = 1'b0;
	reg wake_irq_enable_i = 1'b1, global_irq_enable_i = 1'b1;
	reg [7:0] addr_i = 8'h00, wdata_i = 8'h00;
	reg [2:0] lc = 3'h0;
	wire [7:0] rdata_o;
	wire wake_irq_req_o, irq_o, lirc_hold_o;
	integer n_errors = 0, check_count = 0, n;
	self_wakeup_timer uut (.*);
	initial begin
		forever #5 mclk_i = ~mclk_i;
	end
	// slow clock at an eighth of the system rate, inside the two-to-one limit
	always @(posedge mclk_i) begin
		lc <= lc + 3'h1;
		lirc_i <= lc[2];
	end
	task results;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input [7:0] got, input [7:0] exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		@(posedge mclk_i);
	endtask
	task rd(input [7:0] a, input [7:0] e);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, e);
		@(posedge mclk_i);
	endtask
	task regs;
		rd(8'h86, 8'h00);
		rd(8'h8f, 8'h00);
		wr(8'h8f, 8'he7);
		wr(8'h86, 8'ha5);
		rd(8'h86, 8'ha5);
		rd(8'h8f, 8'h07);
		rd(8'h90, 8'h00);
		rd(8'h40, 8'h00);
		wr(8'h91, 8'h01);
	endtask
	// reload fd gives three steps per overflow; ff stays unused at divide by one
	task roll(input [2:0] ps, input integer lo, input integer hi);
		wr(8'h86, 8'hfd);
		wr(8'h8f, {5'h01, ps});
		n = 0;
		#1;
		while (irq_o !== 1'b1 && n < 300) begin
			@(posedge mclk_i);
			#1 n = n + 1;
		end
		@(posedge mclk_i);
		chk({7'h00, n >= lo && n <= hi}, 8'h01);
		if (n >= 300)
			results;
		rd(8'h90, 8'h03);
		rd(8'h8f, {5'h03, ps});
		chk({7'h00, wake_irq_req_o}, 8'h01);
		wr(8'h8f, 8'h00);
		rd(8'h8f, 8'h00);
	endtask
	initial begin
		repeat (4) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		regs;
		roll(3'h0, 12, 40);
		roll(3'h1, 56, 120);
		results;
	end
endmodule
bind self_wakeup_timer self_wakeup_timer_chk #(.PRE_W(PRE_W)) chk_i (.*);
